// ==== verilog/sbcmw_defs.vh ====
// constants for the mode and wake sequencer: offsets, fields, resets, timings
`ifndef SBCMW_DEFS_VH
`define SBCMW_DEFS_VH
// register byte offsets
`define SBCMW_OFS_WDT 8'h00
`define SBCMW_OFS_WAKE 8'h04
`define SBCMW_OFS_CTRL 8'h08
`define SBCMW_OFS_STAT 8'h0c
`define SBCMW_OFS_MASK 8'h10
// control register fields
`define SBCMW_CTRL_REFRESH 0
`define SBCMW_CTRL_SLEEP 1
`define SBCMW_CTRL_STOP 2
`define SBCMW_CTRL_LPSEL 3
`define SBCMW_CTRL_CYCLIC 4
`define SBCMW_CTRL_CLRSL 5
// reset values
`define SBCMW_WDT_RST 3'h0
`define SBCMW_WAKE_RST 3'h0
`define SBCMW_MASK_RST 4'h0
// modes
`define SBCMW_M_NREQ 3'h0
`define SBCMW_M_NORM 3'h1
`define SBCMW_M_RST 3'h2
`define SBCMW_M_SLEEP 3'h3
`define SBCMW_M_STOP 3'h4
`define SBCMW_M_WAKE 3'h5
`define SBCMW_M_READY 3'h6
// clock and times
`define SBCMW_CLK_KHZ 10000
`define SBCMW_T_NREQ_MS 350
`define SBCMW_T_LPRST_MS 100
`define SBCMW_T_RSTDUR_US 4000
`define SBCMW_T_LX_US 100
`define SBCMW_T_BUS_US 80
`define SBCMW_T_SAMPLE_US 10
`define SBCMW_T_ON_US 200
`define SBCMW_T_READY_US 33
`define SBCMW_T_PULSE_US 10
`define SBCMW_US(t) ((t) * `SBCMW_CLK_KHZ / 1000)
`define SBCMW_MS(t) ((t) * `SBCMW_CLK_KHZ)
`define SBCMW_BUS_PULSES 3
`endif

// ==== verilog/sbcmw_sequencer.v ====
// mode and wake-up sequencer with ahb-lite register slave
// Summary of operation
// - power-up enters normal-request, main on, tracking off
// - no watchdog write in 350 ms: reset, renter
// - watchdog-fault low until first watchdog write
// - first write: normal, tracking on, release outputs
// - missed refresh in normal: reset, back to request
// - undervoltage with stop selected: reset mode
// - that reset entry drives alert low
// - overload clears under stop: restart normal-request
// - undervoltage, sleep, flag cleared: 100 ms reset
// - reset and alert low during that interval
// - interval ends: sleep, both regulators off
// - undervoltage reset keeps watchdog-fault high
// - sleep wake edge: main on after 100 us
// - main above threshold: release reset within 4 ms
// - third bus dominant pulse wakes, 80 us
// - cyclic period from wake timing register
// - sample wake lines 10 us before on-time ends
// - late wake level waits for next activation
// - stop wake edge: alert pulse after 100 us
// - minimum delay after stop alert before ready
// - 2-bit period code, window bit halves window
// - masked condition drives alert low
`timescale 1ns/1ns
`include "sbcmw_defs.vh"
module sbcmw_sequencer
#(
   parameter [31:0] NREQ_CYC = `SBCMW_MS(`SBCMW_T_NREQ_MS),
   parameter [31:0] LPRST_CYC = `SBCMW_MS(`SBCMW_T_LPRST_MS),
   parameter [31:0] RSTDUR_CYC = `SBCMW_US(`SBCMW_T_RSTDUR_US),
   parameter [31:0] WD_MS_CYC = `SBCMW_MS(1),
   parameter [31:0] CS_MS_CYC = `SBCMW_MS(1)
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire main_uv,
   input wire [3:0] wake_input_lines,
   input wire bus_dominant,
   input wire [3:0] alert_conditions,
   output reg reset_n,
   output reg watchdog_fault_out,
   output reg alert_n,
   output reg main_regulator_on,
   output reg tracking_regulator_on,
   output reg high_side_switch,
   output reg [2:0] mode
);
   localparam [31:0] LX_CYC = `SBCMW_US(`SBCMW_T_LX_US);
   localparam [31:0] BUS_CYC = `SBCMW_US(`SBCMW_T_BUS_US);
   localparam [31:0] ON_CYC = `SBCMW_US(`SBCMW_T_ON_US);
   localparam [31:0] SAMP_CYC = ON_CYC - `SBCMW_US(`SBCMW_T_SAMPLE_US);
   localparam [31:0] READY_CYC = `SBCMW_US(`SBCMW_T_READY_US);
   localparam [31:0] PULSE_CYC = `SBCMW_US(`SBCMW_T_PULSE_US);
   // pin synchronisers: first stage is read only by the second
   reg [9:0] sync_a;
   reg [9:0] sync_b;
   reg [3:0] wake_prev;
   reg bus_prev;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_a <= 10'h000;
         sync_b <= 10'h000;
         wake_prev <= 4'h0;
         bus_prev <= 1'b0;
      end
      else
      begin
         sync_a <= {alert_conditions, bus_dominant, main_uv, wake_input_lines};
         sync_b <= sync_a;
         wake_prev <= sync_b[3:0];
         bus_prev <= sync_b[5];
      end
   end
   wire [3:0] wake_lvl = sync_b[3:0];
   wire uv = sync_b[4];
   wire [3:0] alert_lvl = sync_b[9:6];
   wire wake_edge = |(wake_lvl & ~wake_prev);
   wire bus_pulse_end = bus_prev & ~sync_b[5];
   // registers
   reg [2:0] wdt_cfg; // window bit, 2-bit period code
   reg [2:0] wake_cfg;
   reg [3:0] mask;
   reg lp_stop_sel; // selected low-power mode: 1 stop, 0 sleep
   reg cyclic_en;
   reg supply_loss_flag;
   reg wd_written;
   reg wd_refresh;
   reg go_sleep;
   reg go_stop;
   reg clr_supply_loss;
   reg wd_fault_cause;
   // ahb-lite address phase capture; always zero wait, always okay
   reg dp_write;
   reg dp_read;
   reg [7:0] dp_addr;
   reg [31:0] next_rdata;
   wire ap_valid = hsel & htrans[1] & hready;
   // read mux, registered from the address phase
   always @*
   begin
      next_rdata = 32'h0000_0000;
      case (haddr[7:0])
         `SBCMW_OFS_WDT: next_rdata = {29'h0000_0000, wdt_cfg};
         `SBCMW_OFS_WAKE: next_rdata = {29'h0000_0000, wake_cfg};
         `SBCMW_OFS_CTRL: next_rdata = {27'h000_0000, cyclic_en, lp_stop_sel, 3'h0};
         `SBCMW_OFS_STAT: next_rdata = {24'h00_0000, wd_fault_cause, supply_loss_flag,
                                        wd_written, 2'h0, mode};
         `SBCMW_OFS_MASK: next_rdata = {28'h000_0000, mask};
         default: next_rdata = 32'h0000_0000;
      endcase
   end
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         dp_write <= ap_valid & hwrite;
         dp_read <= ap_valid & ~hwrite;
         dp_addr <= haddr[7:0];
         if (ap_valid & ~hwrite)
            hrdata <= next_rdata;
      end
   end
   // register writes in the data phase; command bits are one-cycle strobes
   wire wr_wdt = dp_write & (dp_addr == `SBCMW_OFS_WDT);
   wire wr_ctrl = dp_write & (dp_addr == `SBCMW_OFS_CTRL);
   reg seq_rst; // sequencer-driven reset clears the watchdog config, not the wake config
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdt_cfg <= `SBCMW_WDT_RST;
         wake_cfg <= `SBCMW_WAKE_RST;
         mask <= `SBCMW_MASK_RST;
         lp_stop_sel <= 1'b0;
         cyclic_en <= 1'b0;
         wd_refresh <= 1'b0;
         go_sleep <= 1'b0;
         go_stop <= 1'b0;
         clr_supply_loss <= 1'b0;
      end
      else
      begin
         wd_refresh <= wr_wdt;
         go_sleep <= wr_ctrl & hwdata[`SBCMW_CTRL_SLEEP];
         go_stop <= wr_ctrl & hwdata[`SBCMW_CTRL_STOP];
         clr_supply_loss <= wr_ctrl & hwdata[`SBCMW_CTRL_CLRSL];
         if (seq_rst)
            wdt_cfg <= `SBCMW_WDT_RST;
         else if (wr_wdt)
            wdt_cfg <= hwdata[2:0];
         if (dp_write & (dp_addr == `SBCMW_OFS_WAKE))
            wake_cfg <= hwdata[2:0];
         if (dp_write & (dp_addr == `SBCMW_OFS_MASK))
            mask <= hwdata[3:0];
         if (wr_ctrl)
         begin
            lp_stop_sel <= hwdata[`SBCMW_CTRL_LPSEL];
            cyclic_en <= hwdata[`SBCMW_CTRL_CYCLIC];
         end
      end
   end
   // period tables in ms, 9 bits an entry, code 0 in the low bits
   localparam [35:0] WD_TAB = {9'h15e, 9'h064, 9'h02d, 9'h00a};
   localparam [71:0] CS_TAB = {9'h190, 9'h0c8, 9'h064, 9'h04b, 9'h028, 9'h014, 9'h00a, 9'h005};
   wire [8:0] wd_ms = WD_TAB[wdt_cfg[1:0] * 9 +: 9];
   wire [8:0] cs_ms = CS_TAB[wake_cfg * 9 +: 9];
   wire [31:0] wd_period = wd_ms * WD_MS_CYC;
   wire [31:0] cs_period = cs_ms * CS_MS_CYC;
   // cyclic sense timer: switch on for a short on-time each period
   reg [31:0] cs_cnt;
   reg cs_wake;
   wire lowpow = (mode == `SBCMW_M_SLEEP) | (mode == `SBCMW_M_STOP);
   wire cs_run = lowpow & cyclic_en;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cs_cnt <= 32'h0000_0000;
         cs_wake <= 1'b0;
         high_side_switch <= 1'b0;
      end
      else
      begin
         cs_cnt <= (!cs_run || cs_cnt + 32'h1 >= cs_period) ? 32'h0 : cs_cnt + 32'h1;
         high_side_switch <= cs_run & (cs_cnt < ON_CYC);
         // only one sample per period, so a later level waits for the next period's sample
         cs_wake <= cs_run & (cs_cnt == SAMP_CYC) & (|wake_lvl);
      end
   end
   // bus wake: count every dominant pulse end while asleep or stopped
   reg [1:0] bus_cnt;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         bus_cnt <= 2'h0;
      else if (!lowpow)
         bus_cnt <= 2'h0;
      else if (bus_pulse_end && bus_cnt != `SBCMW_BUS_PULSES)
         bus_cnt <= bus_cnt + 2'h1;
   end
   wire bus_wake = lowpow & bus_pulse_end & (bus_cnt == `SBCMW_BUS_PULSES - 1);
   wire lx_wake = cyclic_en ? cs_wake : wake_edge;
   wire uv_alert = (mode == `SBCMW_M_RST);
   // main sequencer, which also drives the alert output
   reg [31:0] tmr;
   reg [31:0] wd_tmr;
   reg from_stop;
   reg [31:0] pulse_tmr;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode <= `SBCMW_M_NREQ;
         tmr <= 32'h0000_0000;
         wd_tmr <= 32'h0000_0000;
         wd_written <= 1'b0;
         wd_fault_cause <= 1'b0;
         supply_loss_flag <= 1'b1;
         from_stop <= 1'b0;
         seq_rst <= 1'b0;
         main_regulator_on <= 1'b1;
         tracking_regulator_on <= 1'b0;
         reset_n <= 1'b1;
         watchdog_fault_out <= 1'b0;
         pulse_tmr <= 32'h0000_0000;
         alert_n <= 1'b1;
      end
      else
      begin
         seq_rst <= 1'b0;
         tmr <= tmr + 32'h0000_0001;
         wd_tmr <= wd_tmr + 32'h0000_0001;
         if (pulse_tmr != 32'h0000_0000)
            pulse_tmr <= pulse_tmr - 32'h0000_0001;
         alert_n <= ~(|(alert_lvl & mask) | uv_alert | (pulse_tmr != 32'h0));
         if (clr_supply_loss)
            supply_loss_flag <= 1'b0;
         case (mode)
            `SBCMW_M_NREQ:
            begin
               main_regulator_on <= 1'b1;
               tracking_regulator_on <= 1'b0;
               watchdog_fault_out <= 1'b0;
               reset_n <= 1'b1;
               if (uv)
               begin
                  mode <= `SBCMW_M_RST;
                  tmr <= 32'h0000_0000;
               end
               else if (wd_refresh)
               begin
                  mode <= `SBCMW_M_NORM;
                  wd_written <= 1'b1;
                  wd_tmr <= 32'h0000_0000;
                  tracking_regulator_on <= 1'b1;
                  watchdog_fault_out <= 1'b1;
               end
               else if (tmr >= NREQ_CYC - 32'h0000_0001)
               begin
                  // short reset pulse, then a fresh request window
                  reset_n <= 1'b0;
                  wd_fault_cause <= 1'b1;
                  seq_rst <= 1'b1;
                  tmr <= 32'h0000_0000;
               end
            end
            `SBCMW_M_NORM:
            begin
               reset_n <= 1'b1;
               if (uv)
               begin
                  // undervoltage: reset, fault pin stays inactive
                  mode <= `SBCMW_M_RST;
                  reset_n <= 1'b0;
                  watchdog_fault_out <= 1'b1;
                  tmr <= 32'h0000_0000;
               end
               else if ((wd_refresh && wdt_cfg[2] && wd_tmr < (wd_period >> 1)) ||
                        wd_tmr >= wd_period - 32'h0000_0001)
               begin
                  // early refresh in window mode or a missed one
                  mode <= `SBCMW_M_NREQ;
                  reset_n <= 1'b0;
                  wd_fault_cause <= 1'b1;
                  wd_written <= 1'b0;
                  seq_rst <= 1'b1;
                  tracking_regulator_on <= 1'b0;
                  watchdog_fault_out <= 1'b0;
                  tmr <= 32'h0000_0000;
               end
               else if (wd_refresh)
                  wd_tmr <= 32'h0000_0000;
               else if (go_sleep)
               begin
                  mode <= `SBCMW_M_SLEEP;
                  main_regulator_on <= 1'b0;
                  tracking_regulator_on <= 1'b0;
               end
               else if (go_stop)
               begin
                  mode <= `SBCMW_M_STOP;
                  tracking_regulator_on <= 1'b0;
               end
            end
            `SBCMW_M_RST:
            begin
               reset_n <= 1'b0;
               watchdog_fault_out <= 1'b1;
               tracking_regulator_on <= 1'b0;
               if (!lp_stop_sel && !supply_loss_flag && tmr >= LPRST_CYC - 32'h1)
               begin
                  mode <= `SBCMW_M_SLEEP;
                  main_regulator_on <= 1'b0;
               end
               else if ((lp_stop_sel || supply_loss_flag) && !uv)
               begin
                  mode <= `SBCMW_M_NREQ;
                  reset_n <= 1'b1;
                  watchdog_fault_out <= 1'b0;
                  wd_written <= 1'b0;
                  tmr <= 32'h0000_0000;
               end
            end
            `SBCMW_M_SLEEP:
            begin
               main_regulator_on <= 1'b0;
               tracking_regulator_on <= 1'b0;
               reset_n <= 1'b0;
               from_stop <= 1'b0;
               if (lx_wake | bus_wake)
               begin
                  mode <= `SBCMW_M_WAKE;
                  tmr <= lx_wake ? LX_CYC : BUS_CYC;
               end
            end
            `SBCMW_M_STOP:
            begin
               from_stop <= 1'b1;
               if (lx_wake | bus_wake)
               begin
                  mode <= `SBCMW_M_WAKE;
                  tmr <= lx_wake ? LX_CYC : BUS_CYC;
               end
            end
            `SBCMW_M_WAKE:
            begin
               // tmr counts down the detection delay
               tmr <= tmr - 32'h0000_0001;
               if (tmr <= 32'h0000_0001)
               begin
                  mode <= `SBCMW_M_READY;
                  tmr <= 32'h0000_0000;
                  if (from_stop)
                     pulse_tmr <= PULSE_CYC;
                  else
                     main_regulator_on <= 1'b1;
               end
            end
            `SBCMW_M_READY:
            begin
               // after a stop wake the host may already run during this settle time; after sleep reset_n stays low
               if (from_stop)
                  mode <= (tmr >= PULSE_CYC + READY_CYC) ? `SBCMW_M_NORM : mode;
               else if (uv)
                  tmr <= 32'h0000_0000;
               else if (tmr >= RSTDUR_CYC - 32'h0000_0001)
               begin
                  reset_n <= 1'b1;
                  watchdog_fault_out <= 1'b0;
                  mode <= `SBCMW_M_NREQ;
                  wd_written <= 1'b0;
                  tmr <= 32'h0000_0000;
               end
            end
            default: mode <= `SBCMW_M_NREQ;
         endcase
      end
   end
endmodule // sbcmw_sequencer

// ==== verif/sbcmw_assertions.sv ====
// port checker for the mode and wake sequencer
`timescale 1ns/1ns
`include "sbcmw_defs.vh"
module sbcmw_checker
#(
   parameter [31:0] NREQ_CYC = 32'h0000_00c8,
   parameter [31:0] LPRST_CYC = 32'h0000_0064,
   parameter [31:0] RSTDUR_CYC = 32'h0000_0032
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire main_uv,
   input wire reset_n,
   input wire watchdog_fault_out,
   input wire alert_n,
   input wire main_regulator_on,
   input wire tracking_regulator_on,
   input wire [2:0] mode
);
   reg [31:0] n_wait;
   reg [31:0] n_rel;
   reg [31:0] n_lp;
   wire wdt_wr = hsel && htrans[1] && hwrite && hready && haddr[7:0] == `SBCMW_OFS_WDT;
   // run lengths: unanswered request, held reset on good supply, reset mode
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         n_wait <= 32'h0000_0000;
         n_rel <= 32'h0000_0000;
         n_lp <= 32'h0000_0000;
      end
      else
      begin
         n_wait <= (mode == `SBCMW_M_NREQ && reset_n && !wdt_wr) ? n_wait + 1 : 32'h0000_0000;
         n_rel <= (!reset_n && !main_uv && mode != `SBCMW_M_RST) ? n_rel + 1 : 32'h0000_0000;
         n_lp <= (mode == `SBCMW_M_RST) ? n_lp + 1 : 32'h0000_0000;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // uv entries are checked one cycle in, so the registered outputs have landed
   sequence s_norm_entry;
      mode == `SBCMW_M_NREQ ##1 mode == `SBCMW_M_NORM;
   endsequence
   sequence s_uv_reset;
      (mode == `SBCMW_M_RST && main_uv) [*2];
   endsequence
   sequence s_sleep_from_reset;
      mode == `SBCMW_M_RST ##1 mode == `SBCMW_M_SLEEP;
   endsequence
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_NREQ_SUPPLY: assert property (
      mode == `SBCMW_M_NREQ |-> main_regulator_on && !tracking_regulator_on)
      else $error("supplies wrong in normal-request");
   AST_NREQ_FAULT: assert property (mode == `SBCMW_M_NREQ |-> !watchdog_fault_out)
      else $error("fault output released before first write");
   AST_NREQ_TIMEOUT: assert property (n_wait <= NREQ_CYC + 4)
      else $error("no reset after unanswered normal-request");
   AST_NORM_ENTRY: assert property (
      s_norm_entry |-> tracking_regulator_on && watchdog_fault_out && reset_n)
      else $error("normal entered with wrong outputs");
   AST_UV_RESET: assert property (
      s_uv_reset |-> !reset_n && !alert_n && watchdog_fault_out)
      else $error("uv reset outputs wrong");
   AST_SLEEP_ENTRY: assert property (
      $rose(mode == `SBCMW_M_SLEEP) |-> !main_regulator_on && !tracking_regulator_on)
      else $error("regulators on in sleep");
   AST_TIMED_RESET: assert property (
      s_sleep_from_reset |-> n_lp >= LPRST_CYC - 4 && n_lp <= LPRST_CYC + 4)
      else $error("reset before sleep has wrong length");
   AST_RST_RELEASE: assert property (n_rel <= RSTDUR_CYC + 4)
      else $error("reset held too long on good supply");
endmodule // sbcmw_checker

bind sbcmw_sequencer sbcmw_checker #(.NREQ_CYC(NREQ_CYC), .LPRST_CYC(LPRST_CYC),
   .RSTDUR_CYC(RSTDUR_CYC)) sbcmw_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .main_uv(main_uv), .reset_n(reset_n), .watchdog_fault_out(watchdog_fault_out),
   .alert_n(alert_n), .main_regulator_on(main_regulator_on),
   .tracking_regulator_on(tracking_regulator_on), .mode(mode));

// ==== verif/sbcmw_host_model.sv ====
// host-side supply model: main regulator ramp and forced overload
`timescale 1ns/1ns
module sbcmw_host_model
#(
   parameter [31:0] RAMP_CYC = 32'h0000_001e
)
(
   input wire hclk,
   input wire hresetn,
   input wire main_regulator_on,
   input wire overload,
   output wire main_uv
);
   reg [31:0] ramp;
   // reset starts powered so the request phase is not disturbed
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ramp <= RAMP_CYC;
      else if (!main_regulator_on)
         ramp <= 32'h0000_0000;
      else if (ramp < RAMP_CYC)
         ramp <= ramp + 32'h0000_0001;
   end
   // below threshold while off, charging or overloaded
   assign main_uv = overload || ramp < RAMP_CYC;
endmodule // sbcmw_host_model

// ==== verif/sbcmw_sequencer_test.sv ====
// self-checking bench for the mode and wake sequencer
`timescale 1ns/1ns
`include "sbcmw_defs.vh"
module sbcmw_sequencer_test;
   localparam [31:0] NREQ = 32'h0000_00c8;
   localparam [31:0] LPRST = 32'h0000_0064;
   localparam [31:0] RSTDUR = 32'h0000_0032;
   localparam [31:0] STEP = 32'h0000_000a;
   localparam [31:0] RAMP = 32'h0000_001e;
   reg hclk, hresetn, hsel, hwrite, bus_dominant, overload;
   reg [31:0] haddr, hwdata, n, r, m;
   reg [1:0] htrans;
   reg [2:0] hsize;
   reg [3:0] wake_input_lines, alert_conditions;
   wire [31:0] hrdata;
   wire [2:0] mode;
   wire hreadyout, hresp, main_uv, reset_n, watchdog_fault_out, alert_n;
   wire main_regulator_on, tracking_regulator_on, high_side_switch;
   integer n_errors, total_checks, seed, i;

   sbcmw_sequencer #(.NREQ_CYC(NREQ), .LPRST_CYC(LPRST), .RSTDUR_CYC(RSTDUR), .WD_MS_CYC(STEP),
      .CS_MS_CYC(STEP)) sbcmw_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .main_uv(main_uv), .wake_input_lines(wake_input_lines), .bus_dominant(bus_dominant),
      .alert_conditions(alert_conditions), .reset_n(reset_n),
      .watchdog_fault_out(watchdog_fault_out), .alert_n(alert_n),
      .main_regulator_on(main_regulator_on), .tracking_regulator_on(tracking_regulator_on),
      .high_side_switch(high_side_switch), .mode(mode));
   sbcmw_host_model #(.RAMP_CYC(RAMP)) sbcmw_host_model_inst (.hclk(hclk), .hresetn(hresetn),
      .main_regulator_on(main_regulator_on), .overload(overload), .main_uv(main_uv));

   task end_sim;
   begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task check(input string what, input [31:0] seen, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   // timings are compared with a small margin for the input synchronisers
   task near(input string what, input [31:0] seen, input [31:0] exp, input [31:0] tol);
      check(what, (seen + tol >= exp && seen <= exp + tol) ? exp : seen, exp);
   endtask
   function [31:0] wd_cycles(input [1:0] code);
      case (code)
         2'h0: wd_cycles = 10 * STEP;
         2'h1: wd_cycles = 45 * STEP;
         2'h2: wd_cycles = 100 * STEP;
         default: wd_cycles = 350 * STEP;
      endcase
   endfunction
   // 0..6 pick an output level, 8 and up a mode
   function hit(input [3:0] s);
      case (s)
         4'h0: hit = reset_n === 1'b0;
         4'h1: hit = reset_n === 1'b1;
         4'h2: hit = main_regulator_on === 1'b1;
         4'h3: hit = alert_n === 1'b0;
         4'h4: hit = alert_n === 1'b1;
         4'h5: hit = high_side_switch === 1'b1;
         4'h6: hit = high_side_switch === 1'b0;
         default: hit = mode === s[2:0];
      endcase
   endfunction
   // counts whole cycles at settled falling edges, bounded so a stuck design reaches the verdict
   task till(input [3:0] s, output [31:0] c);
   begin
      c = 0;
      @(negedge hclk);
      while (!hit(s) && c < 32'h0000_4e20)
      begin
         @(negedge hclk);
         c = c + 1;
      end
   end
   endtask
   // single word transfer; read data lands in r
   task ahb(input w, input [31:0] a, input [31:0] d);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      r = hrdata;
   end
   endtask
   task to_norm(input [2:0] code);
   begin
      ahb(1'b1, 32'h0000_0000, {29'h0, code});
      till(4'h9, n);
      near("enter normal", n, 32'h0000_0001, 32'h0000_0002);
      check("tracking", tracking_regulator_on, 1'b1);
      check("fault", watchdog_fault_out, 1'b1);
      check("reset", reset_n, 1'b1);
   end
   endtask

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial
   begin
      #(100 * 60000);
      n_errors = n_errors + 1;
      end_sim;
   end
   // main sequence
   initial
   begin
      seed = 32'h45ee;
      n_errors = 0;
      total_checks = 0;
      {hresetn, hsel, hwrite, bus_dominant, overload} = 5'h00;
      {haddr, hwdata, htrans, wake_input_lines, alert_conditions} = 0;
      hsize = 3'h2;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      till(4'h8, n);
      check("main", main_regulator_on, 1'b1);
      check("tracking", tracking_regulator_on, 1'b0);
      check("fault", watchdog_fault_out, 1'b0);
      till(4'h0, n);
      near("request timeout", n, NREQ, 32'h0000_0004);
      check("mode", mode, `SBCMW_M_NREQ);
      // every period code: two early refreshes, then let it run out
      for (i = 0; i < 4; i = i + 1)
      begin
         to_norm(i[2:0]);
         repeat (2)
         begin
            repeat ($unsigned($random(seed)) % (wd_cycles(i[1:0]) / 3)) @(posedge hclk);
            ahb(1'b1, 32'h0000_0000, i);
         end
         till(4'h0, n);
         near("expiry", n, wd_cycles(i[1:0]), 32'h0000_0004);
         till(4'h8, n);
         check("back", n < 32'h0000_0008, 1'b1);
      end
      // refresh in the closed half of a window
      to_norm(3'h4);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
      till(4'h0, n);
      check("early refresh", n < 32'h0000_0008, 1'b1);
      till(4'h8, n);
      // overload with stop selected
      to_norm(3'h3);
      ahb(1'b1, 32'h0000_0008, 32'h0000_0008);
      overload <= 1'b1;
      till(4'ha, n);
      near("uv reset", n, 32'h0000_0003, 32'h0000_0003);
      till(4'ha, n);
      check("reset", reset_n, 1'b0);
      check("alert", alert_n, 1'b0);
      check("fault", watchdog_fault_out, 1'b1);
      @(posedge hclk);
      overload <= 1'b0;
      till(4'h8, n);
      check("restart", n < 32'h0000_0010, 1'b1);
      // overload with sleep selected and supply-loss flag cleared
      to_norm(3'h3);
      ahb(1'b1, 32'h0000_0008, 32'h0000_0020);
      overload <= 1'b1;
      till(4'ha, n);
      till(4'ha, n);
      check("reset", reset_n, 1'b0);
      check("alert", alert_n, 1'b0);
      till(4'hb, n);
      near("timed reset", n, LPRST, 32'h0000_0004);
      check("main", main_regulator_on, 1'b0);
      check("tracking", tracking_regulator_on, 1'b0);
      @(posedge hclk);
      overload <= 1'b0;
      wake_input_lines <= 4'h1 << ($unsigned($random(seed)) % 4);
      till(4'h2, n);
      near("line wake", n, `SBCMW_US(`SBCMW_T_LX_US), 32'h0000_0006);
      till(4'h1, n);
      near("release", n, RAMP + RSTDUR, 32'h0000_0006);
      check("mode", mode, `SBCMW_M_NREQ);
      wake_input_lines <= 4'h0;
      // sleep on request, woken by the third bus pulse only
      to_norm(3'h3);
      ahb(1'b1, 32'h0000_0008, 32'h0000_0002);
      till(4'hb, n);
      for (i = 0; i < 3; i = i + 1)
      begin
         check("asleep", main_regulator_on, 1'b0);
         @(posedge hclk);
         bus_dominant <= 1'b1;
         repeat (20) @(posedge hclk);
         bus_dominant <= 1'b0;
      end
      till(4'h2, n);
      near("bus wake", n, `SBCMW_US(`SBCMW_T_BUS_US), 32'h0000_0006);
      till(4'h1, n);
      // stop, woken by a line: alert pulse then ready
      to_norm(3'h3);
      ahb(1'b1, 32'h0000_0008, 32'h0000_000c);
      till(4'hc, n);
      wake_input_lines <= 4'h8;
      till(4'h3, n);
      near("stop alert", n, `SBCMW_US(`SBCMW_T_LX_US), 32'h0000_0006);
      till(4'h4, n);
      near("pulse", n, `SBCMW_US(`SBCMW_T_PULSE_US), 32'h0000_0003);
      till(4'h9, n);
      near("ready", n, `SBCMW_US(`SBCMW_T_READY_US), 32'h0000_0006);
      wake_input_lines <= 4'h0;
      ahb(1'b0, 32'h0000_0020, 32'h0000_0000);
      check("unmapped", r, 32'h0000_0000);
      // random mask and condition pairs
      for (i = 0; i < 6; i = i + 1)
      begin
         m = $random(seed);
         ahb(1'b1, 32'h0000_0010, m);
         alert_conditions <= m[7:4];
         repeat (4) @(posedge hclk);
         check("masked alert", alert_n, ~|(m[3:0] & m[7:4]));
      end
      // cyclic sense in sleep at the longest period
      ahb(1'b1, 32'h0000_0004, 32'h0000_0007);
      ahb(1'b1, 32'h0000_0008, 32'h0000_0012);
      till(4'h5, n);
      till(4'h6, n);
      till(4'h5, m);
      near("cyclic period", n + m, 400 * STEP, 32'h0000_0004);
      end_sim;
   end
endmodule // sbcmw_sequencer_test
